// file: rtl/las_pkg.sv
// constants for link administration and frame statistics
package las_pkg;
	localparam int NLINK = 12;
	localparam int NCNT  = 10;
	localparam int NFLD  = 12;
	localparam int NEVT  = 11;
	// link state and command codes
	typedef enum logic [1:0] {ST_UP = 2'b00, ST_DOWN = 2'b01, ST_BUSY = 2'b10} las_state_t;
	typedef enum logic [1:0] {CMD_DOWN = 2'b00, CMD_UP = 2'b01, CMD_BUSY = 2'b10} las_cmd_t;
	localparam logic [1:0] TYPE_MAX = 2'h2;
	localparam logic [1:0] ST_RST   = 2'h1;
	// event bit positions and counter indices
	localparam int EV_FRMR = 8;
	localparam int EV_REJ  = 9;
	localparam int EV_DOWN = 10;
	localparam int CNT_FRMR_REJ = 8;
	localparam int CNT_WIDE = 8;
	// speeds in bps
	localparam logic [16:0] SPD_MIN    = 17'h004b0;
	localparam logic [16:0] SPD_MAX    = 17'h11940;
	localparam logic [16:0] SPD_LOW    = 17'h04b00;
	localparam logic [16:0] SPD_DEF    = 17'h02580;
	localparam logic [16:0] SPD_HS_DEF = 17'h0dac0;
	// report fields
	localparam logic [3:0] FLD_STAT = 4'h0;
	localparam logic [3:0] FLD_SPD  = 4'h1;
	localparam logic [3:0] FLD_CNT0 = 4'h2;
	// periodic report time base
	localparam int CLK_NS  = 5;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
endpackage

// file: rtl/las_cnt_if.sv
// interface between the statistics core and one saturating counter
interface las_cnt_if #(parameter int W = 16) ();
	logic         inc;
	logic [W-1:0] val;
	modport ctr (input inc, output val);
	modport usr (output inc, input val);
endinterface

// file: rtl/las_sat_ctr.sv
// one saturating event counter
module las_sat_ctr #(
	parameter int W = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// counter port
	las_cnt_if.ctr   port
);
	logic [W-1:0] cnt_q;
	wire          at_max = &cnt_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= '0;
		end else if (port.inc && !at_max) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
	assign port.val = cnt_q;

	counter_holds_a: assert property (@(posedge clk) disable iff (!rst_b)
		port.inc && at_max |=> cnt_q == $past(cnt_q))
		else $error("counter wrapped past maximum");
	counter_steps_a: assert property (@(posedge clk) disable iff (!rst_b)
		port.inc && !at_max |=> cnt_q == $past(cnt_q) + 1'b1)
		else $error("counter missed an event");
endmodule

// file: rtl/las_link_admin.sv
// per-link administrative state, speed and frame statistics with report stream
module las_link_admin #(
	parameter int TICK_CYC = las_pkg::TICK_CYC
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// operator requests
	input  wire logic        op_valid,
	input  wire logic [1:0]  op_cmd,
	input  wire logic [3:0]  op_link,
	output logic             op_done,
	output logic             op_err,
	output logic [11:0]      vc_clear,
	// speed and type configuration
	input  wire logic        cfg_valid,
	input  wire logic [3:0]  cfg_link,
	input  wire logic [16:0] cfg_speed,
	input  wire logic [1:0]  cfg_type,
	output logic             cfg_err,
	input  wire logic        hs_opt,
	// call admission
	input  wire logic        call_req,
	input  wire logic [3:0]  call_link,
	output logic             call_ok,
	output logic             call_rej,
	// frame events from the line side
	input  wire logic        ev_valid,
	input  wire logic [3:0]  ev_link,
	input  wire logic [10:0] ev_kind,
	// link state view
	output logic [23:0]      link_state,
	output logic [23:0]      link_type,
	// statistics report
	input  wire logic        rpt_req,
	input  wire logic [15:0] rpt_period,
	output logic             rpt_valid,
	output logic [3:0]       rpt_link,
	output logic [3:0]       rpt_field,
	output logic [16:0]      rpt_data,
	output logic             rpt_last
);
	localparam int DW = $clog2(TICK_CYC + 1);

	// ----------------------------------------
	// request decode
	// ----------------------------------------
	wire       op_ok   = op_valid && op_link >= 4'h1 && op_link <= 4'hc
		&& op_cmd != 2'h3;
	wire [3:0] op_idx  = op_link - 4'h1;
	wire       cfg_ok_l = cfg_valid && cfg_link >= 4'h1 && cfg_link <= 4'hc;
	wire [3:0] cfg_idx = cfg_link - 4'h1;
	wire       call_ok_l = call_link >= 4'h1 && call_link <= 4'hc;
	wire [3:0] call_idx = call_link - 4'h1;
	wire       ev_ok   = ev_valid && ev_link >= 4'h1 && ev_link <= 4'hc;
	wire [3:0] ev_idx  = ev_link - 4'h1;
	wire [1:0] op_new  = op_cmd == las_pkg::CMD_UP ? las_pkg::ST_UP
		: op_cmd == las_pkg::CMD_BUSY ? las_pkg::ST_BUSY : las_pkg::ST_DOWN;
	wire [1:0] call_st = link_state[2*call_idx +: 2];
	wire       call_go = call_req && call_ok_l && call_st == las_pkg::ST_UP;

	// ----------------------------------------
	// high-speed strap, caught after reset
	// ----------------------------------------
	logic       hs_s1_q, hs_s2_q, hs_s3_q, hs_q, init_q;
	logic [1:0] strap_q;
	wire        strap_rdy = strap_q == 2'h3 && hs_s2_q == hs_s3_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{hs_s1_q, hs_s2_q, hs_s3_q, hs_q, init_q} <= 5'h00;
			strap_q <= 2'h0;
		end else begin
			{hs_s1_q, hs_s2_q, hs_s3_q} <= {hs_opt, hs_s1_q, hs_s2_q};
			if (strap_q != 2'h3)
				strap_q <= strap_q + 2'h1;
			if (!init_q && strap_rdy) begin
				hs_q   <= hs_s3_q;
				init_q <= 1'b1;
			end
		end
	end

	// speed check: high rates only on link 1 with the option fitted
	wire spd_ok = cfg_speed >= las_pkg::SPD_MIN && cfg_speed <= las_pkg::SPD_MAX
		&& (cfg_speed <= las_pkg::SPD_LOW || (cfg_idx == 4'h0 && hs_q));
	wire cfg_go = init_q && cfg_ok_l && spd_ok && cfg_type <= las_pkg::TYPE_MAX;

	// ----------------------------------------
	// per-link state, type and speed
	// ----------------------------------------
	logic [16:0] spd_q [las_pkg::NLINK];

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < las_pkg::NLINK; i++) begin
				link_state[2*i +: 2] <= las_pkg::ST_RST;
				spd_q[i] <= las_pkg::SPD_DEF;
			end
			link_type <= '0;
		end else begin
			for (int i = 0; i < las_pkg::NLINK; i++) begin
				if (op_ok && op_idx == 4'(i))
					link_state[2*i +: 2] <= op_new;
				if (!init_q && strap_rdy)
					spd_q[i] <= (i == 0 && hs_s3_q) ? las_pkg::SPD_HS_DEF
						: las_pkg::SPD_DEF;
				else if (cfg_go && cfg_idx == 4'(i)) begin
					spd_q[i] <= cfg_speed;
					link_type[2*i +: 2] <= cfg_type;
				end
			end
		end
	end

	// ----------------------------------------
	// request answers
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{op_done, op_err, cfg_err, call_ok, call_rej} <= 5'h00;
			vc_clear <= 12'h000;
		end else begin
			op_done  <= op_ok;
			op_err   <= op_valid && !op_ok;
			cfg_err  <= cfg_valid && !cfg_go;
			call_ok  <= call_go;
			call_rej <= call_req && !call_go;
			vc_clear <= (op_ok && op_cmd == las_pkg::CMD_DOWN)
				? 12'h001 << op_idx : 12'h000;
		end
	end

	// ----------------------------------------
	// statistics counters
	// ----------------------------------------
	// frmr and rej in the same cycle count once; the line side may send them together
	logic [15:0] cval [las_pkg::NLINK][las_pkg::NCNT];

	for (genvar l = 0; l < las_pkg::NLINK; l++) begin : g_lnk
		for (genvar c = 0; c < las_pkg::NCNT; c++) begin : g_cnt
			localparam int W = c < las_pkg::CNT_WIDE ? 16 : 8;
			localparam int EB = c < las_pkg::CNT_FRMR_REJ ? c : las_pkg::EV_DOWN;
			las_cnt_if #(.W(W)) cif ();
			wire hit = c == las_pkg::CNT_FRMR_REJ
				? ev_kind[las_pkg::EV_FRMR] || ev_kind[las_pkg::EV_REJ]
				: ev_kind[EB];
			assign cif.inc = ev_ok && ev_idx == 4'(l) && hit;
			assign cval[l][c] = 16'(cif.val);
			las_sat_ctr #(.W(W)) u_ctr (
				.clk   (clk),
				.rst_b (rst_b),
				.port  (cif)
			);
		end
	end

	// ----------------------------------------
	// report scheduling
	// ----------------------------------------
	// counters keep counting during a report; words are not one snapshot
	logic [DW-1:0] div_q;
	logic [15:0]   per_q;
	logic          pend_q, run_q;
	logic [3:0]    lk_q, fd_q;
	wire           tick    = div_q == DW'(TICK_CYC - 1);
	wire           per_hit = tick && rpt_period != 16'h0000
		&& per_q >= rpt_period - 16'h0001;
	wire           w_end   = fd_q == 4'(las_pkg::NFLD - 1);
	wire           r_end   = w_end && lk_q == 4'(las_pkg::NLINK - 1);
	wire           start   = pend_q && !run_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			div_q  <= '0;
			per_q  <= 16'h0000;
			pend_q <= 1'b0;
			run_q  <= 1'b0;
			lk_q   <= 4'h0;
			fd_q   <= 4'h0;
		end else begin
			div_q  <= tick ? '0 : div_q + 1'b1;
			per_q  <= per_hit ? 16'h0000 : tick ? per_q + 16'h0001 : per_q;
			pend_q <= rpt_req || per_hit || (pend_q && !start);
			if (start)
				run_q <= 1'b1;
			else if (run_q && r_end)
				run_q <= 1'b0;
			if (run_q) begin
				fd_q <= w_end ? 4'h0 : fd_q + 4'h1;
				if (w_end)
					lk_q <= r_end ? 4'h0 : lk_q + 4'h1;
			end
		end
	end

	// ----------------------------------------
	// report words
	// ----------------------------------------
	wire [3:0]  cnt_i  = fd_q - las_pkg::FLD_CNT0;
	wire [16:0] w_stat = {13'h0000, link_type[2*lk_q +: 2], link_state[2*lk_q +: 2]};
	wire [16:0] w_data = fd_q == las_pkg::FLD_STAT ? w_stat
		: fd_q == las_pkg::FLD_SPD ? spd_q[lk_q] : {1'b0, cval[lk_q][cnt_i]};

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rpt_valid <= 1'b0;
			rpt_link  <= 4'h0;
			rpt_field <= 4'h0;
			rpt_data  <= 17'h00000;
			rpt_last  <= 1'b0;
		end else begin
			rpt_valid <= run_q;
			rpt_link  <= lk_q + 4'h1;
			rpt_field <= fd_q;
			rpt_data  <= w_data;
			rpt_last  <= run_q && r_end;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	logic [7:0] nw_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			nw_q <= 8'h00;
		else
			nw_q <= rpt_last ? 8'h00 : rpt_valid ? nw_q + 8'h01 : nw_q;
	end

	link_down_clear_a: assert property (op_ok && op_cmd == las_pkg::CMD_DOWN
		|=> vc_clear == 12'h001 << $past(op_idx)
		&& link_state[2*$past(op_idx) +: 2] == las_pkg::ST_DOWN)
		else $error("link down did not clear circuits");
	link_up_back_a: assert property (op_ok && op_cmd == las_pkg::CMD_UP
		|=> link_state[2*$past(op_idx) +: 2] == las_pkg::ST_UP && op_done)
		else $error("link up did not restore service");
	busy_keeps_calls_a: assert property (op_ok && op_cmd == las_pkg::CMD_BUSY
		|=> vc_clear == 12'h000)
		else $error("busy-out cleared circuits");
	call_refused_a: assert property (call_req && call_ok_l && call_st != las_pkg::ST_UP
		|=> call_rej && !call_ok)
		else $error("call admitted on a link not up");
	bad_index_a: assert property (op_valid && (op_link == 4'h0 || op_link > 4'hc)
		|=> op_err && !op_done && $stable(link_state) && vc_clear == 12'h000)
		else $error("out-of-range request acted on");
	speed_range_a: assert property (init_q |-> spd_q[0] >= las_pkg::SPD_MIN
		&& spd_q[0] <= las_pkg::SPD_MAX && spd_q[1] <= las_pkg::SPD_LOW)
		else $error("link speed out of range");
	speed_default_a: assert property (!init_q && strap_rdy |=> spd_q[2] == las_pkg::SPD_DEF
		&& spd_q[0] == ($past(hs_s3_q) ? las_pkg::SPD_HS_DEF : las_pkg::SPD_DEF))
		else $error("wrong default speed");
	report_start_a: assert property (rpt_req && !run_q |-> ##[1:3] rpt_valid)
		else $error("requested report did not start");
	report_length_a: assert property (rpt_last |-> rpt_valid && nw_q == 8'd143
		&& rpt_link == 4'hc)
		else $error("report length wrong");
	status_code_a: assert property (rpt_valid && rpt_field == las_pkg::FLD_STAT
		|-> rpt_data[1:0] != 2'h3 && rpt_data[3:2] <= las_pkg::TYPE_MAX)
		else $error("bad status word");
endmodule

// file: bench/las_line_peer.sv
// line-side peer delivering frame events to the statistics core
module las_line_peer (
	// clock
	input wire logic    clk,
	// frame events
	output logic        ev_valid,
	output logic [3:0]  ev_link,
	output logic [10:0] ev_kind
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		ev_valid = 1'b0;
		ev_link = 4'h0;
		ev_kind = 11'h000;
	end
	// idle lines show the inverse so stale values never look valid
	task automatic send(input logic [3:0] l, input logic [10:0] k);
		@(posedge clk);
		ev_valid <= 1'b1;
		ev_link <= l;
		ev_kind <= k;
		@(posedge clk);
		ev_valid <= 1'b0;
		ev_link <= ~l;
		ev_kind <= ~k;
	endtask
endmodule

// file: bench/las_link_admin_test.sv
// self-checking bench for link administration and frame statistics
module las_link_admin_test;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------
	// stimulus and observation
	// ----------------
	logic clk = 1'b0, rst_b = 1'b0, op_valid = 1'b0, cfg_valid = 1'b0, call_req = 1'b0;
	logic [1:0] op_cmd = 2'h0, cfg_type = 2'h0;
	logic [3:0] op_link = 4'h0, cfg_link = 4'h0, call_link = 4'h0;
	logic [16:0] cfg_speed = 17'h00000;
	logic rpt_req = 1'b0, hs_opt = 1'b1;
	logic [15:0] rpt_period = 16'h0000;
	logic op_done, op_err, cfg_err, call_ok, call_rej, ev_valid, rpt_valid, rpt_last;
	logic [11:0] vc_clear;
	logic [3:0] ev_link, rpt_link, rpt_field;
	logic [10:0] ev_kind;
	logic [23:0] link_state, link_type;
	logic [16:0] rpt_data;
	int st[16], ty[16], sp[16], cn[16][10];
	int miscompares = 0, checks_done = 0;
	always #2.5 clk = ~clk;
	las_link_admin #(.TICK_CYC(10)) uut (.clk(clk), .rst_b(rst_b), .op_valid(op_valid),
		.op_cmd(op_cmd), .op_link(op_link), .op_done(op_done), .op_err(op_err),
		.vc_clear(vc_clear), .cfg_valid(cfg_valid), .cfg_link(cfg_link),
		.cfg_speed(cfg_speed), .cfg_type(cfg_type), .cfg_err(cfg_err), .hs_opt(hs_opt),
		.call_req(call_req), .call_link(call_link), .call_ok(call_ok), .call_rej(call_rej),
		.ev_valid(ev_valid), .ev_link(ev_link), .ev_kind(ev_kind), .link_state(link_state),
		.link_type(link_type), .rpt_req(rpt_req), .rpt_period(rpt_period),
		.rpt_valid(rpt_valid), .rpt_link(rpt_link), .rpt_field(rpt_field),
		.rpt_data(rpt_data), .rpt_last(rpt_last));
	las_line_peer p (.clk(clk), .ev_valid(ev_valid), .ev_link(ev_link), .ev_kind(ev_kind));
	// ----------------
	// checking and model
	// ----------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	function automatic logic [23:0] pack(input int v[16]);
		logic [23:0] e;
		for (int i = 1; i <= 12; i++) e[2*i-2 +: 2] = 2'(v[i]);
		return e;
	endfunction
	task automatic op(input int c, input int l);
		logic ok;
		ok = l >= 1 && l <= 12 && c != 3;
		@(posedge clk);
		op_valid <= 1'b1;
		op_cmd <= c[1:0];
		op_link <= l[3:0];
		@(posedge clk);
		op_valid <= 1'b0;
		#1;
		chk(op_done, ok);
		chk(op_err, !ok);
		chk(vc_clear, (ok && c == 0) ? 1 << (l - 1) : 0);
		if (ok) st[l] = (c == 0) ? 1 : (c == 1) ? 0 : 2;
		chk(link_state, pack(st));
	endtask
	task automatic call(input int l);
		logic ok;
		ok = l >= 1 && l <= 12 && st[l] == 0;
		@(posedge clk);
		call_req <= 1'b1;
		call_link <= l[3:0];
		@(posedge clk);
		call_req <= 1'b0;
		#1;
		chk(call_ok, ok);
		chk(call_rej, !ok);
	endtask
	task automatic cfg(input int l, input int s, input int t);
		logic ok;
		ok = l >= 1 && l <= 12 && s >= 1200 && s <= 72000 && t != 3
			&& (s <= 19200 || (l == 1 && hs_opt));
		@(posedge clk);
		cfg_valid <= 1'b1;
		cfg_link <= l[3:0];
		cfg_speed <= s[16:0];
		cfg_type <= t[1:0];
		@(posedge clk);
		cfg_valid <= 1'b0;
		#1;
		chk(cfg_err, !ok);
		if (ok) sp[l] = s;
		if (ok) ty[l] = t;
		chk(link_type, pack(ty));
	endtask
	task automatic ev(input int l, input int k);
		p.send(l[3:0], k[10:0]);
		if (l >= 1 && l <= 12) begin
			for (int i = 0; i < 8; i++) if (k[i] && cn[l][i] < 65535) cn[l][i]++;
			if ((k[8] || k[9]) && cn[l][8] < 255) cn[l][8]++;
			if (k[10] && cn[l][9] < 255) cn[l][9]++;
		end
	endtask
	task automatic chk_rpt;
		int n;
		n = 0;
		while (rpt_valid !== 1'b1 && n < 200) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(n < 200, 1);
		for (int l = 1; l <= 12; l++) for (int f = 0; f < 12; f++) begin
			chk(rpt_link, l);
			chk(rpt_field, f);
			chk(rpt_data, f == 0 ? ty[l] * 4 + st[l] : f == 1 ? sp[l] : cn[l][f-2]);
			chk(rpt_valid, 1);
			chk(rpt_last, l == 12 && f == 11);
			@(posedge clk);
			#1;
		end
		chk(rpt_valid, 0);
	endtask
	task automatic rpt;
		@(posedge clk);
		rpt_req <= 1'b1;
		@(posedge clk);
		rpt_req <= 1'b0;
		#1;
		chk_rpt;
	endtask
	// model back to reset values; strap level set while reset is held
	task automatic restart(input logic hs);
		rst_b <= 1'b0;
		hs_opt <= hs;
		rpt_period <= 16'h0000;
		for (int i = 0; i < 16; i++) begin
			st[i] = 1;
			ty[i] = 0;
			sp[i] = (i == 1 && hs) ? 56000 : 9600;
			for (int j = 0; j < 10; j++) cn[i][j] = 0;
		end
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		repeat (8) @(posedge clk);
		#1;
		rpt;
	endtask
	// ----------------
	// sequence
	// ----------------
	initial begin
		#100000;
		miscompares++;
		complete_run;
	end
	initial begin
		void'($urandom(32'h812e));
		restart(1'b1);
		for (int i = 0; i < 16; i++) op(1, i);
		op(0, 3);
		op(2, 5);
		call(5);
		op(1, 5);
		call(5);
		op(3, 2);
		cfg(1, 72000, 2);
		cfg(2, 19201, 1);
		cfg(2, 19200, 1);
		cfg(3, 1199, 0);
		cfg(3, 1200, 3);
		cfg(4, 72001, 0);
		repeat (40) begin
			op($urandom % 4, $urandom % 16);
			call($urandom % 16);
			cfg($urandom % 14, 1100 + $urandom % 20000, $urandom % 4);
		end
		repeat (200) ev($urandom % 16, $urandom % 2048);
		repeat (300) ev(12, 11'h700);
		rpt;
		@(posedge clk);
		rpt_period <= 16'h0002;
		#1;
		chk_rpt;
		// second reset without the high-speed option: link 1 keeps the low rates
		@(posedge clk);
		restart(1'b0);
		cfg(1, 56000, 0);
		cfg(1, 19200, 1);
		rpt;
		complete_run;
	end
endmodule
